/* File: design/interval_timer_window_ctrl.sv */
// Function
// R1: the divisor is ten bits and the timer interrupts at source rate over divisor plus one.
// R2: the divisor low byte is write-only, the upper bits and control byte read back.
// R3: a two-bit source select picks the clock that feeds the timer divider.
// R4: the 100 kHz source is the crystal clock divided by 143, about 100.126 kHz.
// R5: the timer counts while the run bit is one and halts while it is zero.
// R6: colon dot bit zero shows the upper dot of the rightmost colon, one hides it.
// R7: a two-bit attribute picks window colours, upper bit one puts live video behind.
// R8: the size bit picks a 32-line normal or a 64-line large window.
// R9: with the head-switch filter on, the clamp ignores the last lines before front porch.
// R10: a soft-sync write stores nothing and fires one sync when soft sync is selected.
// R11: sync select codes 0..3 pick line 5 start, click rise, rx detect, soft write.
// R12: the master clock from which the 100 kHz source is divided runs at 14.318 MHz.
// R13: the running timer counts ticks, pulses each divisor plus one, and reloads.
//
// The strobed register port was decided locally.
`default_nettype none
module interval_timer_window_ctrl
#(
   parameter int DIV_WIDTH = 10
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic masterTick,
   input wire logic lineTick,
   input wire logic timerClkPin,
   input wire logic [1:0] txSyncSourceSelect,
   input wire logic line5Start,
   input wire logic clickPin,
   input wire logic rxSyncDetect,
   input wire logic filterZone,
   output logic txSync,
   output logic timerIrqPulse,
   output logic colonDotOff,
   output logic [1:0] windowColorAttr,
   output logic videoBackground,
   output logic windowLargeSelect,
   output logic [6:0] windowLines,
   output logic headSwitchFilterEn,
   output logic clampRespond,
   output logic irq
);

   // -----------------------------------------------------------------
   // elaboration check
   // -----------------------------------------------------------------
   // the register map only has room for a ten-bit divisor
   if (DIV_WIDTH != itimer_pkg::DIVISOR_WIDTH)
   begin : gWidthCheck
      $error("interval_timer_window_ctrl: DIV_WIDTH must be 10");
   end

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] divLow;
      logic [1:0] divHigh;
      logic run;
      logic [1:0] srcSel;
      logic colonDotOff;
      logic [1:0] colorAttr;
      logic windowLarge;
      logic head_switch_filter_en;
      logic [1:0] pinS1;
      logic [1:0] pinS2;
      logic [1:0] pinS3;
      logic [1:0] pinLevel;
      logic [7:0] prescale;
      logic tick100k;
      logic txSync;
      logic [1:0] irqStatus;
      logic [1:0] irqMask;
      logic [7:0] rdData;
   } ctl_state_t;

   ctl_state_t st_r;
   ctl_state_t st_nxt;

   logic [DIV_WIDTH-1:0] timerDivisor;
   logic srcTick;
   logic timerPulse;
   logic [1:0] pinRise;
   logic [1:0] pinRaw;
   logic wrDivLow;
   logic wrCtrl;
   logic wrWindow;
   logic wrSoft;
   logic wrStatus;
   logic wrMask;
   logic syncEvent;

   // -----------------------------------------------------------------
   // address decode
   // -----------------------------------------------------------------
   // one decode serves both the write strobes and the read mux
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign wrDivLow = regWrite && hit(regAddr, itimer_pkg::OFS_DIV_LOW);
   assign wrCtrl = regWrite && hit(regAddr, itimer_pkg::OFS_CTRL_HIGH);
   assign wrWindow = regWrite && hit(regAddr, itimer_pkg::OFS_WINDOW);
   assign wrSoft = regWrite && hit(regAddr, itimer_pkg::OFS_SOFT_SYNC);
   assign wrStatus = regWrite && hit(regAddr, itimer_pkg::OFS_IRQ_STATUS);
   assign wrMask = regWrite && hit(regAddr, itimer_pkg::OFS_IRQ_MASK);

   // -----------------------------------------------------------------
   // pin edges
   // -----------------------------------------------------------------
   // a rise counts only from the agreed level, never from the first stage
   assign pinRaw = {clickPin, timerClkPin};

   for (genvar i = 0; i < 2; i++)
   begin : gPinEdge
      assign pinRise[i] = (st_r.pinS2[i] == st_r.pinS3[i]) &&
                          st_r.pinS2[i] && !st_r.pinLevel[i];
   end

   // -----------------------------------------------------------------
   // timer source select
   // -----------------------------------------------------------------
   always_comb
   begin
      unique case (itimer_pkg::timer_src_t'(st_r.srcSel)) // see R3
         itimer_pkg::SRC_MASTER: srcTick = masterTick;
         itimer_pkg::SRC_100K: srcTick = st_r.tick100k; // see R4
         itimer_pkg::SRC_LINE: srcTick = lineTick;
         itimer_pkg::SRC_PIN: srcTick = pinRise[0];
      endcase
   end

   // -----------------------------------------------------------------
   // transmit sync source select
   // -----------------------------------------------------------------
   // changing the select while the transmitter is enabled can fire a
   // stray sync; that is the far side's job to avoid
   always_comb
   begin
      unique case (itimer_pkg::tx_sync_src_t'(txSyncSourceSelect)) // see R11
         itimer_pkg::SYNC_LINE5: syncEvent = line5Start;
         itimer_pkg::SYNC_CLICK: syncEvent = pinRise[1];
         itimer_pkg::SYNC_RX_DETECT: syncEvent = rxSyncDetect;
         itimer_pkg::SYNC_SOFT: syncEvent = wrSoft; // see R10
      endcase
   end

   assign timerDivisor = {st_r.divHigh, st_r.divLow}; // see R1

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;

      // three-stage pin synchroniser and agreed level
      st_nxt.pinS1 = pinRaw;
      st_nxt.pinS2 = st_r.pinS1;
      st_nxt.pinS3 = st_r.pinS2;
      for (int i = 0; i < 2; i++)
      begin
         if (st_r.pinS2[i] == st_r.pinS3[i])
         begin
            st_nxt.pinLevel[i] = st_r.pinS2[i];
         end
      end

      // 14.318 MHz master ticks divided by 143 give the 100 kHz source
      st_nxt.tick100k = 1'b0;
      if (masterTick) // see R12
      begin
         if (st_r.prescale == itimer_pkg::PRESCALE_LAST)
         begin
            st_nxt.prescale = 8'h00;
            st_nxt.tick100k = 1'b1; // see R4
         end
         else
         begin
            st_nxt.prescale = st_r.prescale + 8'h01;
         end
      end

      // register writes; the new divisor is picked up at next reload
      if (wrDivLow)
      begin
         st_nxt.divLow = regWrData; // see R2
      end
      if (wrCtrl)
      begin
         st_nxt.run = regWrData[itimer_pkg::CTRL_RUN_BIT]; // see R5
         st_nxt.srcSel = regWrData[itimer_pkg::CTRL_SRC_LSB +: 2];
         st_nxt.divHigh = regWrData[itimer_pkg::CTRL_DIVHI_LSB +: 2];
      end
      if (wrWindow)
      begin
         st_nxt.colonDotOff = regWrData[itimer_pkg::WIN_DOT_BIT]; // see R6
         st_nxt.colorAttr = regWrData[itimer_pkg::WIN_ATTR_LSB +: 2]; // see R7
         st_nxt.windowLarge = regWrData[itimer_pkg::WIN_LARGE_BIT]; // see R8
         st_nxt.head_switch_filter_en = regWrData[itimer_pkg::WIN_HSF_BIT]; // see R9
      end
      if (wrMask)
      begin
         st_nxt.irqMask = regWrData[1:0];
      end

      // sync pulse: the soft-sync address itself holds no data
      st_nxt.txSync = syncEvent; // see R10

      // sticky status: write one clears, a same-cycle event wins
      if (wrStatus)
      begin
         st_nxt.irqStatus = st_r.irqStatus & ~regWrData[1:0];
      end
      if (timerPulse)
      begin
         st_nxt.irqStatus[itimer_pkg::IRQ_TIMER_BIT] = 1'b1;
      end
      if (st_r.txSync)
      begin
         st_nxt.irqStatus[itimer_pkg::IRQ_TXSYNC_BIT] = 1'b1;
      end

      // read data stands only in the cycle after the strobe
      st_nxt.rdData = 8'h00;
      if (regRead)
      begin
         if (hit(regAddr, itimer_pkg::OFS_CTRL_HIGH))
         begin
            st_nxt.rdData = {st_r.run, st_r.srcSel, 3'h0, st_r.divHigh}; // see R2
         end
         else if (hit(regAddr, itimer_pkg::OFS_WINDOW))
         begin
            st_nxt.rdData = {3'h0, st_r.head_switch_filter_en, st_r.windowLarge,
                             st_r.colorAttr, st_r.colonDotOff};
         end
         else if (hit(regAddr, itimer_pkg::OFS_IRQ_STATUS))
         begin
            st_nxt.rdData = {6'h00, st_r.irqStatus};
         end
         else if (hit(regAddr, itimer_pkg::OFS_IRQ_MASK))
         begin
            st_nxt.rdData = {6'h00, st_r.irqMask};
         end
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   // synchronous reset; clock enable low freezes everything
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         st_r <= '0;
         st_r.divLow <= itimer_pkg::RST_DIV_LOW;
         st_r.run <= itimer_pkg::RST_CTRL_HIGH[itimer_pkg::CTRL_RUN_BIT];
         st_r.colonDotOff <= itimer_pkg::RST_WINDOW[itimer_pkg::WIN_DOT_BIT];
         st_r.irqMask <= itimer_pkg::RST_IRQ_MASK;
      end
      else if (clkEn)
      begin
         st_r <= st_nxt;
      end
   end

   // -----------------------------------------------------------------
   // interval counter
   // -----------------------------------------------------------------
   timer_divider #(
      .DIV_WIDTH(DIV_WIDTH)
   ) uDivider (
      .refClk(ref_clk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .run(st_r.run), // see R5
      .srcTick(srcTick),
      .timerDivisor(timerDivisor),
      .timerPulse(timerPulse)
   );

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign regRdData = st_r.rdData;
   assign txSync = st_r.txSync;
   assign timerIrqPulse = timerPulse;
   assign colonDotOff = st_r.colonDotOff; // see R6
   assign windowColorAttr = st_r.colorAttr; // see R7
   assign videoBackground = st_r.colorAttr[1]; // see R7
   assign windowLargeSelect = st_r.windowLarge;
   assign windowLines = st_r.windowLarge ? itimer_pkg::WIN_LINES_LARGE :
                        itimer_pkg::WIN_LINES_NORMAL; // see R8
   assign headSwitchFilterEn = st_r.head_switch_filter_en;
   // clamp masked only inside the zone and only with the filter on
   assign clampRespond = !(st_r.head_switch_filter_en && filterZone); // see R9
   // level interrupt from registered status and mask
   assign irq = |(st_r.irqStatus & st_r.irqMask);

endmodule
`default_nettype wire

/* File: design/itimer_pkg.sv */
`default_nettype none
package itimer_pkg;
   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_DIV_LOW = 8'h3c;
   localparam logic [7:0] OFS_CTRL_HIGH = 8'h3d;
   localparam logic [7:0] OFS_WINDOW = 8'h3e;
   localparam logic [7:0] OFS_SOFT_SYNC = 8'h3f;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h41;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int CTRL_RUN_BIT = 7;
   localparam int CTRL_SRC_LSB = 5;
   localparam int CTRL_DIVHI_LSB = 0;
   localparam int WIN_HSF_BIT = 4;
   localparam int WIN_LARGE_BIT = 3;
   localparam int WIN_ATTR_LSB = 1;
   localparam int WIN_DOT_BIT = 0;
   localparam int IRQ_TIMER_BIT = 0;
   localparam int IRQ_TXSYNC_BIT = 1;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_DIV_LOW = 8'h00;
   localparam logic [7:0] RST_CTRL_HIGH = 8'h00;
   localparam logic [7:0] RST_WINDOW = 8'h00;
   localparam logic [1:0] RST_IRQ_MASK = 2'h0;

   // -----------------------------------------------------------------
   // widths, encodings and timing
   // -----------------------------------------------------------------
   localparam int DIVISOR_WIDTH = 10;
   localparam int MASTER_CLK_KHZ = 14318;
   localparam int PRESCALE_DIV = 143;
   localparam logic [7:0] PRESCALE_LAST = 8'(PRESCALE_DIV - 1);
   localparam logic [6:0] WIN_LINES_NORMAL = 7'h20;
   localparam logic [6:0] WIN_LINES_LARGE = 7'h40;

   typedef enum logic [1:0] {
      SRC_MASTER = 2'h0,
      SRC_100K = 2'h1,
      SRC_LINE = 2'h2,
      SRC_PIN = 2'h3
   } timer_src_t;

   typedef enum logic [1:0] {
      SYNC_LINE5 = 2'h0,
      SYNC_CLICK = 2'h1,
      SYNC_RX_DETECT = 2'h2,
      SYNC_SOFT = 2'h3
   } tx_sync_src_t;
endpackage
`default_nettype wire

/* File: design/timer_divider.sv */
`default_nettype none
module timer_divider
#(
   parameter int DIV_WIDTH = 10
)
(
   input wire logic refClk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic run,
   input wire logic srcTick,
   input wire logic [DIV_WIDTH-1:0] timerDivisor,
   output logic timerPulse
);

   // -----------------------------------------------------------------
   // elaboration check
   // -----------------------------------------------------------------
   if (DIV_WIDTH < 1 || DIV_WIDTH > 16)
   begin : gWidthCheck
      $error("timer_divider: DIV_WIDTH out of range");
   end

   typedef struct packed {
      logic [DIV_WIDTH-1:0] count;
      logic pulse;
   } div_state_t;

   div_state_t st_r;
   div_state_t st_nxt;

   // -----------------------------------------------------------------
   // down counter with automatic reload
   // -----------------------------------------------------------------
   // stopped timer keeps reloading so a new divisor is ready at start
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.pulse = 1'b0;
      if (!run)
      begin
         st_nxt.count = timerDivisor; // see R5
      end
      else if (srcTick)
      begin
         if (st_r.count == '0)
         begin
            st_nxt.pulse = 1'b1; // see R1
            st_nxt.count = timerDivisor; // see R13
         end
         else
         begin
            st_nxt.count = st_r.count - 1'b1; // see R13
         end
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge refClk)
   begin
      if (!reset_n)
      begin
         st_r <= '0;
      end
      else if (clkEn)
      begin
         st_r <= st_nxt;
      end
   end

   assign timerPulse = st_r.pulse;

endmodule
`default_nettype wire

/* File: test/itimer_checker_sva.sv */
`default_nettype none
module itimer_checker
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic [1:0] txSyncSourceSelect,
   input wire logic line5Start,
   input wire logic rxSyncDetect,
   input wire logic filterZone,
   input wire logic txSync,
   input wire logic colonDotOff,
   input wire logic [1:0] windowColorAttr,
   input wire logic videoBackground,
   input wire logic windowLargeSelect,
   input wire logic [6:0] windowLines,
   input wire logic headSwitchFilterEn,
   input wire logic clampRespond
);
   // -----------------------------------------------------------------
   // port relations
   // -----------------------------------------------------------------
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   clamp_gate_a: assert property (
      clampRespond == !(headSwitchFilterEn && filterZone))
      else $error("clamp gating wrong");
   video_bg_a: assert property (
      videoBackground == windowColorAttr[1])
      else $error("video background not attr msb");
   win_lines_a: assert property (
      windowLines == (windowLargeSelect ? 7'h40 : 7'h20))
      else $error("window height wrong");
   // fields land the cycle after the write
   win_write_a: assert property (
      clkEn && regWrite && regAddr == 8'h3e |=>
      {headSwitchFilterEn, windowLargeSelect, windowColorAttr, colonDotOff}
      == $past(regWrData[4:0]))
      else $error("window write not applied");
   soft_sync_a: assert property (
      clkEn && regWrite && regAddr == 8'h3f && txSyncSourceSelect == 2'h3
      |=> txSync)
      else $error("soft sync missing");
   line5_sync_a: assert property (
      clkEn && line5Start && txSyncSourceSelect == 2'h0 |=> txSync)
      else $error("line sync missing");
   rx_sync_a: assert property (
      clkEn && rxSyncDetect && txSyncSourceSelect == 2'h2 |=> txSync)
      else $error("receive sync missing");
   div_low_read_a: assert property (
      clkEn && regRead && regAddr == 8'h3c |=> regRdData == 8'h00)
      else $error("write-only divisor readable");
endmodule

bind interval_timer_window_ctrl itimer_checker chk (.ref_clk, .reset_n,
   .clkEn, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
   .txSyncSourceSelect, .line5Start, .rxSyncDetect, .filterZone, .txSync,
   .colonDotOff, .windowColorAttr, .videoBackground, .windowLargeSelect,
   .windowLines, .headSwitchFilterEn, .clampRespond);
`default_nettype wire

/* File: test/test_interval_timer_window_ctrl.sv */
`default_nettype none
module test_interval_timer_window_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [15:0] q;} row_t;
   logic ref_clk = 0, reset_n = 0, clkEn = 1, regWrite = 0, regRead = 0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
   logic masterTick = 1, lineTick = 0, timerClkPin = 0, line5Start = 0;
   logic clickPin = 0, rxSyncDetect = 0, filterZone = 1;
   logic [1:0] txSyncSourceSelect = 2'h0, windowColorAttr;
   logic txSync, timerIrqPulse, colonDotOff, videoBackground, irq;
   logic windowLargeSelect, headSwitchFilterEn, clampRespond;
   logic [6:0] windowLines;
   int miscompares = 0, totalChecks = 0;
   // register rows: address, data written, value read back
   row_t regRows [8] = '{'{8'h3c, 8'hff, 0}, '{8'h3d, 8'hff, 16'he3},
      '{8'h3e, 8'hff, 16'h1f}, '{8'h3e, 8'h0a, 16'h0a},
      '{8'h3e, 8'h15, 16'h15}, '{8'h41, 8'h00, 0},
      '{8'h50, 8'ha5, 0}, '{8'h3f, 8'h77, 0}};
   // timer rows: control byte, divisor low, period in clocks
   // last row: pin source, a rise every 8 clocks, two rises a period
   row_t tmrRows [5] = '{'{8'h80, 8'h04, 5}, '{8'h81, 8'h01, 258},
      '{8'ha0, 8'h00, 143}, '{8'hc0, 8'h02, 6}, '{8'he0, 8'h01, 16}};

   interval_timer_window_ctrl uut (.ref_clk, .reset_n, .clkEn, .regAddr,
      .regWrData, .regWrite, .regRead, .regRdData, .masterTick, .lineTick,
      .timerClkPin, .txSyncSourceSelect, .line5Start, .clickPin,
      .rxSyncDetect, .filterZone, .txSync, .timerIrqPulse, .colonDotOff,
      .windowColorAttr, .videoBackground, .windowLargeSelect, .windowLines,
      .headSwitchFilterEn, .clampRespond, .irq);

   // -----------------------------------------------------------------
   // clock, line source and tasks
   // -----------------------------------------------------------------
   initial forever #5 ref_clk = ~ref_clk;
   // line ticks every other clock so source two differs from source zero
   always @(posedge ref_clk) lineTick <= ~lineTick;
   // timer pin slow enough that the second and third stages agree
   logic [2:0] pinDiv = 3'h0;
   always @(posedge ref_clk) pinDiv <= pinDiv + 3'h1;
   always @(posedge ref_clk) timerClkPin <= pinDiv[2];

   task automatic check(input string name, input logic [15:0] got, exp);
      totalChecks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] q);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1;
      check("regRdData", regRdData, q);
   endtask

   // counts pulses from the current cycle on
   task automatic cnt(input bit tmr, input int cyc, input logic [15:0] exp);
      int n;
      n = 0;
      repeat (cyc)
      begin
         if ((tmr ? timerIrqPulse : txSync) === 1'b1) n++;
         @(posedge ref_clk);
         #1;
      end
      check(tmr ? "timerPulses" : "syncPulses", 16'(n), exp);
   endtask

   // bounded: a stuck timer must not hang the run
   task automatic period(input logic [15:0] exp);
      int n;
      n = 0;
      while (timerIrqPulse !== 1'b1 && n < 600)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      n = 0;
      do
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      while (timerIrqPulse !== 1'b1 && n < 600);
      check("period", 16'(n), exp);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      #100000;
      miscompares++;
      final_report();
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(8'h3d, 0);
      check("windowLines", windowLines, 16'h20);
      check("clampRespond", clampRespond, 1);
      $display("reset test done");
      foreach (regRows[i])
      begin
         wr(regRows[i].a, regRows[i].d);
         if (regRows[i].a == 8'h3e)
         begin
            check("colonDotOff", colonDotOff, regRows[i].d[0]);
            check("attr", windowColorAttr, regRows[i].d[2:1]);
            check("videoBg", videoBackground, regRows[i].d[2]);
            check("large", windowLines, regRows[i].d[3] ? 7'h40 : 7'h20);
            check("clampRespond", clampRespond, !regRows[i].d[4]);
         end
         rd(regRows[i].a, regRows[i].q);
      end
      $display("register test done");
      foreach (tmrRows[i])
      begin
         wr(8'h3d, 8'h00); // stopped, so the new divisor loads
         wr(8'h3c, tmrRows[i].d);
         wr(8'h3d, tmrRows[i].a);
         period(tmrRows[i].q);
      end
      wr(8'h3d, 8'h00);
      repeat (2) @(posedge ref_clk);
      cnt(1'b1, 300, 0);
      $display("timer test done");
      for (int s = 0; s < 4; s++)
      begin
         txSyncSourceSelect <= 2'(s);
         if (s == 3) wr(8'h3f, 8'h5a);
         else
         begin
            @(posedge ref_clk);
            line5Start <= (s == 0);
            clickPin <= (s == 1);
            rxSyncDetect <= (s == 2);
            @(posedge ref_clk);
            {line5Start, rxSyncDetect} <= 2'h0;
            #1;
         end
         cnt(1'b0, 10, 1);
      end
      txSyncSourceSelect <= 2'h0;
      wr(8'h3f, 8'h5a);
      cnt(1'b0, 10, 0);
      $display("sync test done");
      rd(8'h40, 16'h03);
      check("irqMasked", irq, 0);
      wr(8'h41, 8'h02);
      @(posedge ref_clk);
      #1;
      check("irqRaised", irq, 1);
      wr(8'h40, 8'h02);
      @(posedge ref_clk);
      #1;
      check("irqCleared", irq, 0);
      rd(8'h40, 16'h01);
      $display("interrupt test done");
      // clock enable low: a write must not land
      clkEn <= 1'b0;
      wr(8'h3e, 8'h0a);
      clkEn <= 1'b1;
      rd(8'h3e, 16'h15);
      // reset in mid-run clears fields and status
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(8'h3e, 16'h00);
      rd(8'h40, 16'h00);
      check("windowLines", windowLines, 16'h20);
      check("irqAfterReset", irq, 0);
      $display("freeze and reset test done");
      final_report();
   end
endmodule
`default_nettype wire
